// ==== rss_map.vh ====
`ifndef RSS_MAP_VH
`define RSS_MAP_VH
// Register byte offsets
`define RSS_CAUSE_OFFSET 12'h000
`define RSS_SRC_OFFSET 12'h004
// Cause register field positions
`define RSS_BIT_TRAP 15
`define RSS_BIT_ILLOP 14
`define RSS_BIT_CFGMM 9
`define RSS_BIT_VREG 8
`define RSS_BIT_PIN 7
`define RSS_BIT_SOFT 6
`define RSS_BIT_SWDT 5
`define RSS_BIT_TIMEOUT 4
`define RSS_BIT_SLEEP 3
`define RSS_BIT_IDLE 2
`define RSS_BIT_BROWNOUT 1
`define RSS_BIT_POR 0
// Power-on value and implemented-bit mask
`define RSS_CAUSE_RESET 16'h0003
`define RSS_CAUSE_MASK 16'hC3FF
// Extra master reset cycles after power-on
`define RSS_POR_STRETCH 2'h2
// Response codes
`define RSS_RESP_OKAY 2'b00
`define RSS_RESP_SLVERR 2'b10
`endif

// ==== rss_sync.v ====
`timescale 1ns/1ps
// Two-stage synchroniser for a vector of levels
module rss_sync #(
    parameter W = 9
) (
    input wire clk_sys_i,
    input wire resetn_i,
    input wire [W-1:0] async_i,
    output reg [W-1:0] sync_o
);
    reg [W-1:0] stage1;

    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            stage1 <= {W{1'b0}};
            sync_o <= {W{1'b0}};
        end
        else
        begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule // rss_sync

// ==== rss_reset_source_status.v ====
`timescale 1ns/1ps
`include "rss_map.vh"
module rss_reset_source_status (
    input wire clk_sys_i,
    input wire resetn_i,
    input wire brownout_reset_i,
    input wire external_pin_reset_i,
    input wire reset_instruction_i,
    input wire watchdog_timeout_i,
    input wire config_mismatch_i,
    input wire trap_conflict_i,
    input wire illegal_opcode_i,
    input wire uninit_pointer_reset_i,
    input wire power_save_instruction_i,
    input wire enter_sleep_i,
    input wire enter_idle_i,
    input wire fuse_watchdog_enable_i,
    input wire [11:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output reg s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output reg s_axi_wready_o,
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [11:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output reg s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i,
    output reg master_reset_n_o,
    output reg watchdog_enable_o,
    output reg regulator_sleep_keep_o
);
    // resetn_i is the power-on reset; the other inputs apart from clk_sys_i, AXI, fuse_watchdog_enable_i and the power-state events are source inputs
    // Lanes of the source synchroniser
    localparam SRC_PIN = 0;
    localparam SRC_CFGMM = 1;
    localparam SRC_TRAP = 2;
    localparam SRC_ILLOP = 3;
    localparam SRC_UNINIT = 4;
    localparam SRC_POWER_SAVE = 5;
    localparam SRC_SLEEP = 6;
    localparam SRC_IDLE = 7;

    // Decoded register addresses; the decode ignores the low two bits
    localparam [11:0] CAUSE_ADDR = `RSS_CAUSE_OFFSET;
    localparam [11:0] SRC_ADDR = `RSS_SRC_OFFSET;

    wire [7:0] src_async;
    wire [7:0] src;
    reg [15:0] reset_cause_register;
    reg [15:0] next_cause;
    reg por_seen;
    reg [1:0] por_cnt;
    reg aw_held;
    reg w_held;
    reg [11:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [31:0] next_rdata;
    reg [1:0] next_rresp;
    wire any_src;
    wire do_write;
    wire wr_cause;
    wire ev_trap;
    wire ev_illop;
    wire ev_cfgmm;
    wire ev_pin;
    wire ev_soft;
    wire ev_timeout;
    wire ev_brownout;
    wire ev_sleep;
    wire ev_idle;
    wire ev_power_save;

    assign src_async = {enter_idle_i, enter_sleep_i, power_save_instruction_i,
        uninit_pointer_reset_i, illegal_opcode_i, trap_conflict_i,
        config_mismatch_i, external_pin_reset_i};

    rss_sync #(
        .W(8)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .async_i(src_async),
        .sync_o(src)
    );

    // Same-domain sources, no synchroniser
    assign ev_soft = reset_instruction_i;
    assign ev_timeout = watchdog_timeout_i;
    assign ev_brownout = brownout_reset_i;
    // Synchronised sources and power-state events
    assign ev_pin = src[SRC_PIN];
    assign ev_cfgmm = src[SRC_CFGMM];
    assign ev_trap = src[SRC_TRAP];
    assign ev_illop = src[SRC_ILLOP] | src[SRC_UNINIT];
    assign ev_power_save = src[SRC_POWER_SAVE];
    assign ev_sleep = src[SRC_SLEEP];
    assign ev_idle = src[SRC_IDLE];

    assign any_src = ev_brownout | ev_pin | ev_soft | ev_timeout |
        ev_cfgmm | ev_trap | ev_illop |
        (por_cnt != 2'h0);

    // Only byte lanes 0 and 1 reach the register
    function [15:0] merge_bytes;
        input [15:0] old_val;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge_bytes = old_val;
            if (strb[0])
                merge_bytes[7:0] = data[7:0];
            if (strb[1])
                merge_bytes[15:8] = data[15:8];
        end
    endfunction

    function is_cause;
        input [11:0] addr;
        begin
            is_cause = (addr[11:2] == CAUSE_ADDR[11:2]);
        end
    endfunction

    function is_src;
        input [11:0] addr;
        begin
            is_src = (addr[11:2] == SRC_ADDR[11:2]);
        end
    endfunction

    // Write lands once both halves are held
    assign do_write = aw_held && w_held && !s_axi_bvalid_o;
    assign wr_cause = do_write && is_cause(aw_addr);

    // Read-back word for the address on the read channel
    always @*
    begin
        next_rdata = 32'h0000_0000;
        next_rresp = `RSS_RESP_OKAY;
        if (is_cause(s_axi_araddr_i))
            next_rdata = {16'h0000, reset_cause_register};
        else if (is_src(s_axi_araddr_i))
            next_rdata = {21'h00_0000, any_src, watchdog_enable_o,
                src, 1'b0};
        else
            next_rresp = `RSS_RESP_SLVERR;
    end

    // Next cause value: software write first, hardware events win
    always @*
    begin
        next_cause = reset_cause_register;
        if (wr_cause)
            next_cause = merge_bytes(reset_cause_register, w_data, w_strb);
        if (ev_power_save)
            next_cause[`RSS_BIT_TIMEOUT] = 1'b0;
        if (ev_trap)
            next_cause[`RSS_BIT_TRAP] = 1'b1;
        if (ev_illop)
            next_cause[`RSS_BIT_ILLOP] = 1'b1;
        if (ev_cfgmm)
            next_cause[`RSS_BIT_CFGMM] = 1'b1;
        if (ev_pin)
            next_cause[`RSS_BIT_PIN] = 1'b1;
        if (ev_soft)
            next_cause[`RSS_BIT_SOFT] = 1'b1;
        if (ev_timeout)
            next_cause[`RSS_BIT_TIMEOUT] = 1'b1;
        if (ev_sleep)
            next_cause[`RSS_BIT_SLEEP] = 1'b1;
        if (ev_idle)
            next_cause[`RSS_BIT_IDLE] = 1'b1;
        if (ev_brownout)
            next_cause[`RSS_BIT_BROWNOUT] = 1'b1;
        next_cause = next_cause & `RSS_CAUSE_MASK;
    end

    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            reset_cause_register <= `RSS_CAUSE_RESET;
        else
            reset_cause_register <= next_cause;
    end

    // Stretch master reset two cycles past power-on release
    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            por_cnt <= `RSS_POR_STRETCH;
            por_seen <= 1'b0;
            master_reset_n_o <= 1'b0;
        end
        else
        begin
            if (por_cnt != 2'h0)
                por_cnt <= por_cnt - 2'h1;
            por_seen <= 1'b1;
            master_reset_n_o <= por_seen & ~any_src;
        end
    end

    // Control outputs from the register
    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            watchdog_enable_o <= 1'b0;
            regulator_sleep_keep_o <= 1'b0;
        end
        else
        begin
            watchdog_enable_o <= next_cause[`RSS_BIT_SWDT] |
                fuse_watchdog_enable_i;
            regulator_sleep_keep_o <= next_cause[`RSS_BIT_VREG];
        end
    end

    // AXI4-Lite write channel
    // One write in flight; ready waits until the response is taken
    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `RSS_RESP_OKAY;
        end
        else
        begin
            s_axi_awready_o <= !aw_held && !s_axi_awready_o &&
                s_axi_awvalid_i;
            s_axi_wready_o <= !w_held && !s_axi_wready_o && s_axi_wvalid_i;
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
            if (do_write)
            begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= (is_cause(aw_addr) || is_src(aw_addr)) ?
                    `RSS_RESP_OKAY : `RSS_RESP_SLVERR;
            end
            else if (s_axi_bvalid_o && s_axi_bready_i)
            begin
                s_axi_bvalid_o <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel
    // Read address is taken only with no answer pending
    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= `RSS_RESP_OKAY;
        end
        else
        begin
            s_axi_arready_o <= !s_axi_arready_o && !s_axi_rvalid_o &&
                s_axi_arvalid_i;
            if (s_axi_arvalid_i && s_axi_arready_o)
            begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= next_rdata;
                s_axi_rresp_o <= next_rresp;
            end
            else if (s_axi_rvalid_o && s_axi_rready_i)
                s_axi_rvalid_o <= 1'b0;
        end
    end
endmodule // rss_reset_source_status

// ==== rss_chk_asserts.sv ====
`timescale 1ns/1ps
module rss_chk (
    input logic clk_sys_i,
    input logic resetn_i,
    input logic brownout_reset_i,
    input logic reset_instruction_i,
    input logic watchdog_timeout_i,
    input logic external_pin_reset_i,
    input logic config_mismatch_i,
    input logic trap_conflict_i,
    input logic illegal_opcode_i,
    input logic uninit_pointer_reset_i,
    input logic fuse_watchdog_enable_i,
    input logic s_axi_arvalid_i,
    input logic s_axi_arready_o,
    input logic s_axi_rvalid_o,
    input logic master_reset_n_o,
    input logic watchdog_enable_o
);
    logic [2:0] quiet;
    wire sync_src = external_pin_reset_i | config_mismatch_i |
        trap_conflict_i | illegal_opcode_i | uninit_pointer_reset_i;
    wire busy = sync_src | brownout_reset_i | reset_instruction_i |
        watchdog_timeout_i;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // Cycles since the last reset request
    always_ff @(posedge clk_sys_i or negedge resetn_i)
        if (!resetn_i)
            quiet <= 3'h0;
        else if (busy)
            quiet <= 3'h0;
        else if (quiet != 3'h7)
            quiet <= quiet + 3'h1;
    mrst_now_a: assert property (
        (brownout_reset_i | reset_instruction_i | watchdog_timeout_i)
        |=> !master_reset_n_o) else $error("master reset late");
    mrst_sync_a: assert property (
        $rose(sync_src) |-> ##[1:4] !master_reset_n_o)
        else $error("synced source lost");
    por_hold_a: assert property (disable iff (1'b0)
        $rose(resetn_i) |-> !master_reset_n_o ##1 !master_reset_n_o)
        else $error("power-on stretch short");
    rst_state_a: assert property (disable iff (1'b0)
        !resetn_i |-> !master_reset_n_o && !watchdog_enable_o)
        else $error("outputs wrong in power-on");
    quiet_run_a: assert property (
        quiet == 3'h7 |-> master_reset_n_o)
        else $error("master reset without request");
    wdog_fuse_a: assert property (
        $past(fuse_watchdog_enable_i) && $past(resetn_i)
        |-> watchdog_enable_o) else $error("fuse does not force watchdog");
    ar_take_a: assert property (
        $rose(s_axi_arvalid_i) |-> ##[1:2] s_axi_arready_o)
        else $error("read address not taken");
    rd_answer_a: assert property (
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
    cover property (!master_reset_n_o ##1 master_reset_n_o);
    cover property (fuse_watchdog_enable_i && watchdog_enable_o);
    cover property (s_axi_rvalid_o);
endmodule // rss_chk
bind rss_reset_source_status rss_chk u_chk (.*);

// ==== rss_src_model.sv ====
`timescale 1ns/1ps
module rss_src_model (
    input logic clk_sys_i,
    input logic [10:0] req_i,
    output logic [10:0] src_o
);
    logic [10:0] d1 = '0, d2 = '0, d3 = '0;
    always_ff @(posedge clk_sys_i)
    begin
        d1 <= req_i;
        d2 <= d1;
        d3 <= d2;
    end
    assign src_o = req_i | d1 | d2 | d3;
endmodule // rss_src_model

// ==== rss_reset_source_status_tb.sv ====
`timescale 1ns/1ps
module rss_reset_source_status_tb;
    logic clk_sys_i = 0, resetn_i, fuse_watchdog_enable_i = 0;
    logic [11:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
    logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o, d;
    logic [3:0] s_axi_wstrb_i = '0;
    logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
    logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, aw, w;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic s_axi_arready_o, s_axi_rvalid_o, master_reset_n_o;
    logic watchdog_enable_o, regulator_sleep_keep_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, bq[$];
    logic [33:0] rq[$];
    logic [10:0] req = '0, src;
    wire brownout_reset_i, external_pin_reset_i, reset_instruction_i;
    wire watchdog_timeout_i, config_mismatch_i, trap_conflict_i;
    wire illegal_opcode_i, uninit_pointer_reset_i;
    wire power_save_instruction_i, enter_sleep_i, enter_idle_i;
    int checks = 0, fails = 0;
    int bt[11] = '{1, 7, 6, 4, 9, 15, 14, 14, 4, 3, 2};
    assign {enter_idle_i, enter_sleep_i, power_save_instruction_i,
        uninit_pointer_reset_i, illegal_opcode_i, trap_conflict_i,
        config_mismatch_i, watchdog_timeout_i, reset_instruction_i,
        external_pin_reset_i, brownout_reset_i} = src;
    rss_src_model model (.clk_sys_i(clk_sys_i), .req_i(req), .src_o(src));
    rss_reset_source_status uut (.*);
    always #5 clk_sys_i = ~clk_sys_i;
    task automatic chk(input [33:0] got, input [33:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input [11:0] a, input [31:0] v, input [3:0] s,
        input [1:0] r);
        bq.push_back(r);
        @(posedge clk_sys_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= v;
        s_axi_wstrb_i <= s;
        s_axi_awvalid_i <= 1;
        s_axi_wvalid_i <= 1;
        s_axi_bready_i <= 1;
        aw = 1;
        w = 1;
        while (aw || w)
        begin
            @(posedge clk_sys_i);
            if (aw && s_axi_awready_o)
                s_axi_awvalid_i <= 0;
            if (w && s_axi_wready_o)
                s_axi_wvalid_i <= 0;
            aw = aw && !s_axi_awready_o;
            w = w && !s_axi_wready_o;
        end
        do @(posedge clk_sys_i); while (!s_axi_bvalid_o);
        s_axi_bready_i <= 0;
    endtask
    task automatic rd(input [11:0] a, input [31:0] e, input [1:0] r);
        rq.push_back({r, e});
        @(posedge clk_sys_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1;
        s_axi_rready_i <= 1;
        do @(posedge clk_sys_i); while (!s_axi_arready_o);
        s_axi_arvalid_i <= 0;
        do @(posedge clk_sys_i); while (!s_axi_rvalid_o);
        s_axi_rready_i <= 0;
    endtask
    task automatic pulse(input int i);
        @(posedge clk_sys_i);
        req[i] <= 1;
        @(posedge clk_sys_i);
        req[i] <= 0;
        repeat (8) @(posedge clk_sys_i);
    endtask
    task automatic summarize;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk_sys_i)
    begin
        if (s_axi_rvalid_o && s_axi_rready_i)
            chk({s_axi_rresp_o, s_axi_rdata_o}, rq.pop_front());
        if (s_axi_bvalid_o && s_axi_bready_i)
            chk(s_axi_bresp_o, bq.pop_front());
    end
    initial
    begin
        #200000;
        fails++;
        summarize();
    end
    initial
    begin
        void'($urandom(77301));
        resetn_i <= 0;
        repeat (5) @(posedge clk_sys_i);
        resetn_i <= 1;
        repeat (6) @(posedge clk_sys_i);
        chk(master_reset_n_o, 1);
        rd(0, 32'h0000_0003, 0);
        $display("power-on done");
        for (int i = 0; i < 11; i++)
            if (i != 8)
            begin
                wr(0, 0, 4'hF, 0);
                pulse(i);
                rd(0, 32'h1 << bt[i], 0);
            end
        wr(0, 32'h0000_0010, 4'hF, 0);
        pulse(8);
        rd(0, 0, 0);
        $display("sources done");
        repeat (4)
        begin
            d = $urandom;
            wr(0, d, 4'hF, 0);
            rd(0, {16'h0000, d[15:0] & 16'hC3FF}, 0);
            chk(regulator_sleep_keep_o, d[8]);
            chk(watchdog_enable_o, d[5]);
        end
        wr(0, 32'hFFFF_FFFF, 4'h1, 0);
        rd(0, {16'h0000, d[15:0] & 16'hC300 | 16'h00FF}, 0);
        wr(0, 0, 4'hF, 0);
        fuse_watchdog_enable_i <= 1;
        repeat (3) @(posedge clk_sys_i);
        chk(watchdog_enable_o, 1);
        rd(12'h004, 32'h0000_0200, 0);
        fuse_watchdog_enable_i <= 0;
        wr(12'h008, 32'hFFFF_FFFF, 4'hF, 2'b10);
        rd(12'h008, 0, 2'b10);
        rd(0, 0, 0);
        chk(watchdog_enable_o, 0);
        wr(0, 32'h0000_0120, 4'h3, 0);
        pulse(1);
        rd(0, 32'h0000_01A0, 0);
        chk(regulator_sleep_keep_o, 1);
        $display("software access done");
        resetn_i <= 0;
        repeat (2) @(posedge clk_sys_i);
        resetn_i <= 1;
        repeat (6) @(posedge clk_sys_i);
        rd(0, 32'h0000_0003, 0);
        $display("second power-on done");
        summarize();
    end
endmodule // rss_reset_source_status_tb
